// file: pkg/dbl_pkg.sv
package dbl_pkg;
  // ==========================================================
  // widths and counts
  localparam int DATA_W       = 16;
  localparam int BYTE_W       = 8;
  localparam int NUM_CONV     = 3;
  localparam int FIFO_DEPTH   = 8;
  localparam int CLK_PERIOD_NS = 100;
  // ==========================================================
  // timing figures in ns, converted to cycles (least times round up)
  localparam int SEL_LOW_NS    = 300;
  localparam int SEL_LOW_CYC   = (SEL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_NS       = 100;
  localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RANK_GAP_NS   = 100;
  localparam int RANK_GAP_CYC  = (RANK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_HIGH_NS  = 100;
  localparam int LOAD_HIGH_CYC = (LOAD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;
  // ==========================================================
  // modes
  typedef enum logic [1:0] {
    DBL_MODE_EDGE,
    DBL_MODE_MULTI,
    DBL_MODE_BYTE
  } dbl_mode_t;
endpackage : dbl_pkg

// file: hdl/dbl_fifo.sv
`timescale 1ns/10ps
module dbl_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      rp_reg;
  logic             push;
  logic             pop;
  assign wr_ready_out = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
  assign rd_valid_out = wp_reg != rp_reg;
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_data_out  = mem_reg[rp_reg[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wp_reg[AW-1:0]] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
    end
  end
  a_fifo_no_overrun : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wp_reg - rp_reg) <= (AW+1)'(DEPTH)) else $error("fifo overrun");
endmodule : dbl_fifo

// file: hdl/dbl_host.sv
`timescale 1ns/10ps
module dbl_host #(
  parameter int NCONV    = dbl_pkg::NUM_CONV,
  parameter int DIV      = 16,
  parameter int WAIT_CYC = dbl_pkg::SEL_LOW_CYC
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire dbl_pkg::dbl_mode_t         mode_in,
  input  wire logic                       use_pin_trigger_in,
  input  wire logic                       sample_interrupt_in,
  input  wire logic                       word_valid_in,
  output logic                            word_ready_out,
  input  wire logic [dbl_pkg::DATA_W-1:0] word_data_in,
  input  wire logic [1:0]                 word_conv_in,
  input  wire logic                       word_last_in,
  output logic [dbl_pkg::DATA_W-1:0]      bus_data_out,
  output logic                            bus_data_oe_out,
  output logic [NCONV-1:0]                decoded_select_n_out,
  output logic                            first_rank_load_n_out,
  output logic                            second_rank_load_out,
  output logic                            byte_latch_en_out,
  output logic                            busy_out
);
  import dbl_pkg::*;
  initial begin
    if (NCONV < 1 || NCONV > 4 || DIV < 2 || WAIT_CYC < 1 || WAIT_CYC > 15) $error("bad parameter");
  end
  // ==========================================================
  // reset release and pin synchroniser
  logic [1:0] rst_sync_reg;
  logic       rst_b;
  logic [1:0] irq_sync_reg;
  logic       irq_prev_reg;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_b = rst_sync_reg[1];
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      irq_sync_reg <= 2'b00;
      irq_prev_reg <= 1'b0;
    end else begin
      irq_sync_reg <= {irq_sync_reg[0], sample_interrupt_in};
      irq_prev_reg <= irq_sync_reg[1];
    end
  end
  // ==========================================================
  // sample trigger: divider is synchronous to clk_in, so no jitter
  logic [15:0] div_reg;
  logic        tick;
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) div_reg <= '0;
    else if (div_reg == 16'(DIV - 1)) div_reg <= '0;
    else div_reg <= div_reg + 16'h0001;
  end
  assign tick = use_pin_trigger_in ? (irq_sync_reg[1] && !irq_prev_reg) : (div_reg == 16'(DIV - 1));
  // ==========================================================
  // word buffer: upstream stalls while the fifo is full
  localparam int FW = DATA_W + 3;
  logic [FW-1:0] f_data;
  logic          f_valid;
  logic          f_pop;
  dbl_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b),
    .wr_valid_in  (word_valid_in),
    .wr_ready_out (word_ready_out),
    .wr_data_in   ({word_last_in, word_conv_in, word_data_in}),
    .rd_valid_out (f_valid),
    .rd_ready_in  (f_pop),
    .rd_data_out  (f_data)
  );
  // ==========================================================
  // write sequencer
  typedef enum logic [2:0] {
    ST_IDLE, ST_BYTE_HI, ST_LOW, ST_HOLD, ST_GAP, ST_LOAD
  } dbl_state_t;
  dbl_state_t       st_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [1:0]       conv_reg;
  logic             last_reg;
  logic             pending_reg;
  // lower byte kept aside: the fifo head moves on to the next word at the pop
  logic [BYTE_W-1:0] low_byte_reg;
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) pending_reg <= 1'b0;
    else if (tick) pending_reg <= 1'b1; // a trigger landing on the consume cycle is kept
    else if (st_reg == ST_IDLE && f_valid) pending_reg <= 1'b0;
  end
  assign f_pop = (st_reg == ST_IDLE) && f_valid && (pending_reg || mode_in == DBL_MODE_MULTI);
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      st_reg   <= ST_IDLE;
      cnt_reg  <= '0;
      conv_reg <= 2'b00;
      last_reg <= 1'b0;
      bus_data_out <= '0;
      low_byte_reg <= '0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (f_pop) begin
            conv_reg <= f_data[DATA_W+1:DATA_W];
            last_reg <= f_data[DATA_W+2];
            low_byte_reg <= f_data[BYTE_W-1:0];
            if (mode_in == DBL_MODE_BYTE) begin
              bus_data_out <= {{BYTE_W{1'b0}}, f_data[DATA_W-1:BYTE_W]};
              st_reg <= ST_BYTE_HI;
            end else begin
              bus_data_out <= f_data[DATA_W-1:0];
              st_reg <= ST_LOW;
            end
            cnt_reg <= CNT_W'(WAIT_CYC - 1);
          end
        end
        ST_BYTE_HI: begin
          if (cnt_reg == '0) begin
            bus_data_out <= {{BYTE_W{1'b0}}, low_byte_reg};
            cnt_reg <= CNT_W'(WAIT_CYC - 1);
            st_reg  <= ST_LOW;
          end else cnt_reg <= cnt_reg - 1'b1;
        end
        ST_LOW: begin
          if (cnt_reg == '0) begin
            cnt_reg <= CNT_W'(HOLD_CYC - 1);
            st_reg  <= ST_HOLD;
          end else cnt_reg <= cnt_reg - 1'b1;
        end
        ST_HOLD: begin
          // data held after the strobe rise, select rises afterwards (in edge mode select rises on entry to ST_HOLD)
          if (cnt_reg == '0) begin
            if (mode_in == DBL_MODE_MULTI && last_reg) begin
              cnt_reg <= CNT_W'(RANK_GAP_CYC - 1);
              st_reg  <= ST_GAP;
            end else st_reg <= ST_IDLE;
          end else cnt_reg <= cnt_reg - 1'b1;
        end
        ST_GAP: begin
          if (cnt_reg == '0) begin
            cnt_reg <= CNT_W'(LOAD_HIGH_CYC - 1);
            st_reg  <= ST_LOAD;
          end else cnt_reg <= cnt_reg - 1'b1;
        end
        ST_LOAD: begin
          if (cnt_reg == '0) st_reg <= ST_IDLE;
          else cnt_reg <= cnt_reg - 1'b1;
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // pin decode from state (address is registered, so no decode glitch)
  logic sel_act;
  logic strobe_act;
  assign sel_act    = (st_reg == ST_LOW) || (st_reg == ST_HOLD) || (st_reg == ST_BYTE_HI);
  assign strobe_act = (st_reg == ST_LOW) && (mode_in != DBL_MODE_EDGE);
  always_comb begin
    decoded_select_n_out = {NCONV{1'b1}};
    if (sel_act && st_reg != ST_BYTE_HI) begin
      if (mode_in == DBL_MODE_EDGE) decoded_select_n_out = ~(NCONV'(st_reg == ST_LOW) << conv_reg);
      else decoded_select_n_out = ~(NCONV'(1) << conv_reg);
    end
  end
  // edge mode: load tied with select, strobe tied low at the device
  assign first_rank_load_n_out = (mode_in == DBL_MODE_EDGE) ? 1'b0 : !strobe_act;
  assign second_rank_load_out  = (mode_in == DBL_MODE_EDGE) ? !(st_reg == ST_LOW)
                               : (mode_in == DBL_MODE_MULTI) ? (st_reg == ST_LOAD)
                               : 1'b1;
  assign byte_latch_en_out = (st_reg == ST_BYTE_HI);
  assign bus_data_oe_out   = sel_act;
  assign busy_out          = (st_reg != ST_IDLE);
  // ==========================================================
  // time in ST_LOW (select low before the hold), counted apart from the sequencer's own counter
  logic [CNT_W-1:0] low_len_reg;
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) low_len_reg <= '0;
    else if (st_reg == ST_LOW) low_len_reg <= low_len_reg + 1'b1;
    else low_len_reg <= '0;
  end
  sequence s_gap_then_load;
    (st_reg == ST_GAP) ##1 (st_reg == ST_LOAD && second_rank_load_out);
  endsequence
  // ==========================================================
  // checks
  a_load_after_gap : assert property (@(posedge clk_in) disable iff (!rst_b)
    $rose(st_reg == ST_LOAD) |-> $past(st_reg) == ST_GAP) else $error("load without gap");
  a_select_low_len : assert property (@(posedge clk_in) disable iff (!rst_b)
    $fell(st_reg == ST_LOW) |-> low_len_reg == CNT_W'(WAIT_CYC)) else $error("select too short");
  a_strobe_in_sel : assert property (@(posedge clk_in) disable iff (!rst_b)
    !first_rank_load_n_out && mode_in != DBL_MODE_EDGE |-> !(&decoded_select_n_out))
    else $error("strobe outside select");
  a_hold_after_wr : assert property (@(posedge clk_in) disable iff (!rst_b)
    $fell(st_reg == ST_LOW) |-> bus_data_oe_out && $stable(bus_data_out)) else $error("data dropped early");
  a_edge_rank_tie : assert property (@(posedge clk_in) disable iff (!rst_b)
    mode_in == DBL_MODE_EDGE |-> second_rank_load_out == (&decoded_select_n_out)) else $error("edge tie");
  a_load_pulse_end : assert property (@(posedge clk_in) disable iff (!rst_b)
    $rose(st_reg == ST_LOAD) |-> ##[1:16] st_reg == ST_IDLE) else $error("load stuck");
  a_byte_order : assert property (@(posedge clk_in) disable iff (!rst_b)
    $fell(byte_latch_en_out) |-> st_reg == ST_LOW) else $error("byte order");
  a_trigger_kept : assert property (@(posedge clk_in) disable iff (!rst_b)
    tick |=> pending_reg) else $error("trigger lost");
  a_rank_update : assert property (@(posedge clk_in) disable iff (!rst_b)
    st_reg == ST_HOLD && cnt_reg == '0 && last_reg && mode_in == DBL_MODE_MULTI |=> s_gap_then_load)
    else $error("shared load missing");
  a_oe_with_select : assert property (@(posedge clk_in) disable iff (!rst_b)
    !(&decoded_select_n_out) |-> bus_data_oe_out) else $error("select without data");
  a_byte_no_select : assert property (@(posedge clk_in) disable iff (!rst_b)
    byte_latch_en_out |-> &decoded_select_n_out) else $error("select during upper byte");
endmodule : dbl_host

// file: test/dbl_dev_model.sv
`timescale 1ns/10ps
// ==========================================================
// two-rank level latch of one converter
module dbl_dev_model #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] bus_in,
  input  wire logic         sel_n_in,
  input  wire logic         load_n_in,
  input  wire logic         load2_in,
  output logic      [W-1:0] rank1_out,
  output logic      [W-1:0] dac_out
);
  // both ranks open together pass data straight through; edge use needs select and load opposite
  always_latch begin
    if (!sel_n_in && !load_n_in) rank1_out <= bus_in;
  end
  always_latch begin
    if (load2_in) dac_out <= rank1_out;
  end
endmodule : dbl_dev_model

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import dbl_pkg::*;
  // ==========================================================
  // wiring
  localparam int NC = NUM_CONV;
  logic clk_in, rst_b_in, use_pin_trigger_in, sample_interrupt_in, word_valid_in, word_last_in;
  logic bus_data_oe_out, first_rank_load_n_out, second_rank_load_out, byte_latch_en_out, busy_out, word_ready_out;
  logic [1:0]            word_conv_in;
  logic [DATA_W-1:0]     word_data_in, bus_data_out, last_bus, bus_w, din;
  logic [NC-1:0]         decoded_select_n_out;
  logic [BYTE_W-1:0]     upper_q;
  logic [DATA_W-1:0]     rank1 [NC];
  logic [DATA_W-1:0]     dac [NC];
  dbl_mode_t             mode_in;
  int                    errors, n_checks, low_n;
  dbl_host #(.NCONV(NC), .DIV(4), .WAIT_CYC(SEL_LOW_CYC)) dbl_host_inst (.clk_in, .rst_b_in, .mode_in,
    .use_pin_trigger_in, .sample_interrupt_in, .word_valid_in, .word_ready_out, .word_data_in, .word_conv_in,
    .word_last_in, .bus_data_out, .bus_data_oe_out, .decoded_select_n_out, .first_rank_load_n_out,
    .second_rank_load_out, .byte_latch_en_out, .busy_out);
  // released bus shows the inverse of its last value, not a stale copy
  always @(posedge clk_in) if (bus_data_oe_out) last_bus <= bus_data_out;
  assign bus_w = bus_data_oe_out ? bus_data_out : ~last_bus;
  // octal latch sampled on the clock, so the byte swap at the enable's fall cannot race it
  always @(posedge clk_in) if (byte_latch_en_out) upper_q <= bus_w[BYTE_W-1:0];
  assign din = (mode_in == DBL_MODE_BYTE) ? {upper_q, bus_w[BYTE_W-1:0]} : bus_w;
  for (genvar i = 0; i < NC; i++) begin : g_dev
    dbl_dev_model dbl_dev_model_inst (.bus_in(din), .sel_n_in(decoded_select_n_out[i]),
      .load_n_in(first_rank_load_n_out), .load2_in(second_rank_load_out), .rank1_out(rank1[i]), .dac_out(dac[i]));
  end
  always @(posedge clk_in) begin
    if (!(&decoded_select_n_out)) low_n <= low_n + 1;
    else begin
      if (low_n != 0) check(16'(low_n >= SEL_LOW_CYC), 16'h0001);
      low_n <= 0;
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic timeout;
    errors++;
    $display("unexpected at %0t: wait ran out", $time);
    give_verdict();
  endtask : timeout
  task automatic push(input logic [DATA_W-1:0] d, input logic [1:0] c, input logic l);
    int k;
    k = 0;
    @(posedge clk_in);
    word_data_in <= d;
    word_conv_in <= c;
    word_last_in <= l;
    word_valid_in <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
    end while (word_ready_out !== 1'b1 && k < 400);
    word_valid_in <= 1'b0;
    if (k >= 400) timeout();
  endtask : push
  // idle for 12 cycles means the fifo is drained: divider triggers come every 4
  task automatic wait_idle;
    int k, q;
    q = 0;
    for (k = 0; k < 2000 && q < 12; k++) begin
      @(posedge clk_in);
      q = (busy_out === 1'b0) ? q + 1 : 0;
    end
    if (q < 12) timeout();
  endtask : wait_idle
  task automatic pulse_trigger;
    @(posedge clk_in);
    sample_interrupt_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    sample_interrupt_in <= 1'b0;
    wait_idle();
  endtask : pulse_trigger
  // ==========================================================
  // scenarios
  task automatic t_edge;
    push(16'hA5C3, 2'h0, 1'b1);
    push(16'h5A3C, 2'h2, 1'b1);
    wait_idle();
    check(dac[0], 16'hA5C3);
    check(dac[2], 16'h5A3C);
    $display("edge test done");
  endtask : t_edge
  task automatic t_multi;
    mode_in <= DBL_MODE_MULTI;
    push(16'h1234, 2'h0, 1'b0);
    push(16'h4321, 2'h1, 1'b0);
    wait_idle();
    check(rank1[0], 16'h1234);
    check(dac[0], 16'hA5C3);
    push(16'hBEEF, 2'h2, 1'b1);
    wait_idle();
    check(dac[0], 16'h1234);
    check(dac[1], 16'h4321);
    check(dac[2], 16'hBEEF);
    $display("multi test done");
  endtask : t_multi
  task automatic t_byte;
    mode_in <= DBL_MODE_BYTE;
    push(16'hC35A, 2'h1, 1'b1);
    wait_idle();
    check(dac[1], 16'hC35A);
    $display("byte test done");
  endtask : t_byte
  // mid-run reset drops a divider trigger left pending before the pin takes over
  task automatic t_pin;
    mode_in <= DBL_MODE_EDGE;
    use_pin_trigger_in <= 1'b1;
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check(16'(decoded_select_n_out), 16'({NC{1'b1}}));
    check(16'(busy_out), 16'h0000);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    push(16'h0FF0, 2'h0, 1'b1);
    wait_idle();
    check(dac[0], 16'h1234);
    pulse_trigger();
    check(dac[0], 16'h0FF0);
    $display("pin trigger test done");
  endtask : t_pin
  // fill without triggers until refused, then drain one trigger at a time
  task automatic t_fifo;
    for (int k = 0; k < FIFO_DEPTH; k++) push(16'h1000 + 16'(k), 2'h0, 1'b1);
    @(posedge clk_in);
    check(16'(word_ready_out), 16'h0000);
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      pulse_trigger();
      check(dac[0], 16'h1000 + 16'(k));
    end
    $display("fifo test done");
  endtask : t_fifo
  // ==========================================================
  // clock and main sequence
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    errors = 0;
    n_checks = 0;
    low_n = 0;
    last_bus = 16'h0000;
    rst_b_in = 1'b0;
    mode_in = DBL_MODE_EDGE;
    use_pin_trigger_in = 1'b0;
    sample_interrupt_in = 1'b0;
    word_valid_in = 1'b0;
    word_data_in = 16'h0000;
    word_conv_in = 2'h0;
    word_last_in = 1'b0;
    repeat (12) @(posedge clk_in);
    check(16'(decoded_select_n_out), 16'({NC{1'b1}}));
    check(16'(bus_data_oe_out), 16'h0000);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_edge();
    t_multi();
    t_byte();
    t_pin();
    t_fifo();
    give_verdict();
  end
endmodule : testbench
